// ==== hw/ors_pkg.sv ====
package ors_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ORS_IDX_STAT     = 8'h07;               // Status and control index.
  localparam logic [7:0] ORS_ADDR_STAT    = 8'h1c;               // Four times the index.
  localparam logic [7:0] ORS_ADDR_CFG     = 8'h00;               // Timing and display configuration.
  localparam logic [7:0] ORS_ADDR_MASK    = 8'h04;               // Interrupt mask.
  localparam logic [7:0] ORS_ADDR_LINE    = 8'h08;               // Line and row position, read only.
  localparam logic [7:0] ORS_ADDR_PAL     = 8'h20;               // Palette for index 1; index n at +4*(n-1).
  localparam int         ORS_NUM_PAL      = 7;                   // Palettes reachable by a nonzero index.

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ORS_ST_HFLAG   = 0;                             // Row event flag.
  localparam int ORS_ST_VFLAG   = 1;                             // Vertical event flag.
  localparam int ORS_ST_HEN     = 2;                             // Row interrupt enable.
  localparam int ORS_ST_PMODE   = 3;                             // Palette mode.
  localparam int ORS_ST_FRGB_LO = 4;                             // Fringe RGB field, bits 6..4.
  localparam int ORS_ST_FSEL    = 7;                             // Fringe colour select.
  localparam int ORS_CF_DBL     = 4;                             // Doubled row height.
  localparam int ORS_CF_PROG    = 5;                             // Progressive scan mode.
  localparam int ORS_CF_FEN     = 6;                             // Fringe enable.
  localparam int ORS_CF_HPOL    = 7;                             // Hsync active low when set.
  localparam int ORS_CF_VPOL    = 8;                             // Vsync active low when set.

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] ORS_STAT_RST   = 8'h00;                 // Status and control after reset.
  localparam logic [8:0] ORS_CFG_RST    = 9'h000;                // Configuration after reset.
  localparam logic [1:0] ORS_MASK_RST   = 2'h0;                  // All sources masked after reset.
  localparam logic [5:0] ORS_PAL_RST    = 6'h00;                 // Palette entry after reset.
  localparam logic [5:0] ORS_LINES_NORM = 6'h12;                 // Scan lines in a normal row.
  localparam logic [5:0] ORS_LINES_DBL  = 6'h24;                 // Scan lines in a doubled row.
  localparam logic [1:0] ORS_RESP_OKAY  = 2'h0;                  // Bus answer, success.
  localparam logic [1:0] ORS_RESP_SLV   = 2'h2;                  // Bus answer, unmapped address.

  // ---------------------------------------------------------------
  // Interrupt service state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ORS_SRV_NONE = 2'b00,
    ORS_SRV_ROW  = 2'b01,
    ORS_SRV_VERT = 2'b10
  } ors_srv_t;

endpackage

// ==== hw/ors_sync_edge.sv ====
`timescale 1ns/1ps
module ors_sync_edge (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Raw pin and its active polarity.
  input  wire logic pin,
  input  wire logic active_low,
  // Leading edge pulse.
  output logic      lead_pulse
);
  import ors_pkg::*;

  logic s1_reg;    // First stage, read only by the second.
  logic s2_reg;    // Second stage.
  logic s3_reg;    // Third stage.
  logic lvl_reg;   // Accepted level once stages two and three agree.

  // ---------------------------------------------------------------
  // Three-stage synchroniser.
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ---------------------------------------------------------------
  // A change counts once stages agree; the asserting edge pulses once.
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_reg    <= 1'b0;
      lead_pulse <= 1'b0;
    end else begin
      lead_pulse <= 1'b0;
      if (s2_reg == s3_reg) begin
        lvl_reg    <= s3_reg ^ active_low;
        lead_pulse <= (s3_reg ^ active_low) & ~lvl_reg;
      end
    end
  end
endmodule

// ==== hw/ors_top.sv ====
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module ors_top (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // AXI4-Lite write address channel.
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Sync pins from the video front end.
  input  wire logic       hsync,
  input  wire logic       vsync,
  // Pixel request from the character generator.
  input  wire logic       pix_valid,
  input  wire logic [2:0] pix_sel,
  input  wire logic [2:0] pix_row_fg,
  input  wire logic [2:0] pix_row_bg,
  input  wire logic       pix_fore,
  input  wire logic       pix_edge,
  // Pixel colour out.
  output logic [2:0]      pix_rgb,
  output logic            pix_rgb_valid,
  // Timing events and interrupt.
  output logic            row_start,
  output logic            field_start,
  output logic            irq
);
  import ors_pkg::*;

  // ---------------------------------------------------------------
  // Address decode shared by reads and writes
  // ---------------------------------------------------------------
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ORS_ADDR_STAT) || (a == ORS_ADDR_CFG) ||
                  (a == ORS_ADDR_MASK) || (a == ORS_ADDR_LINE) ||
                  ((a >= ORS_ADDR_PAL) && (a < ORS_ADDR_PAL + 8'(4 * ORS_NUM_PAL)) && (a[1:0] == 2'h0));
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic        h_lead;                   // Hsync leading edge pulse.
  logic        v_lead;                   // Vsync leading edge pulse.
  logic [7:0]  aw_addr_reg;              // Captured write address.
  logic        aw_got_reg;               // Write address held.
  logic [31:0] w_data_reg;               // Captured write data.
  logic [3:0]  w_strb_reg;               // Captured byte enables.
  logic        w_got_reg;                // Write data held.
  logic        wr_fire;                  // Write takes effect this cycle.
  logic        lane0;                    // Low byte written.
  logic        lane1;                    // Second byte written.
  logic [7:2]  ctl_reg;                  // Control bits of the status register.
  logic        hflag_reg;                // Row event flag.
  logic        vflag_reg;                // Vertical event flag.
  logic [8:0]  cfg_reg;                  // Configuration.
  logic [1:0]  mask_reg;                 // Interrupt mask.
  logic [5:0]  pal_reg [ORS_NUM_PAL];    // Palettes, bg in [2:0], fg in [5:3].
  logic [5:0]  line_reg;                 // Scan line within the row.
  logic [3:0]  row_reg;                  // Rows since the field began.
  logic [5:0]  row_len;                  // Lines in the current row.
  logic        h_ok;                     // Row flag may interrupt.
  logic        v_ok;                     // Vertical flag may interrupt.
  ors_srv_t    srv_reg;                  // Source now in service.
  logic [31:0] rd_word;                  // Read multiplexer.
  logic [2:0]  pal_idx;                  // Palette index of a read address.
  logic [2:0]  wpal_idx;                 // Palette index of a write address.

  // ---------------------------------------------------------------
  // Sync inputs
  // ---------------------------------------------------------------
  ors_sync_edge u_hsync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin        (hsync),
    .active_low (cfg_reg[ORS_CF_HPOL]),
    .lead_pulse (h_lead)
  );

  ors_sync_edge u_vsync (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pin        (vsync),
    .active_low (cfg_reg[ORS_CF_VPOL]),
    .lead_pulse (v_lead)
  );

  // ---------------------------------------------------------------
  // Write channels: address and data in either order, then answer.
  // ---------------------------------------------------------------
  assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign lane0   = wr_fire && w_strb_reg[0];
  assign lane1   = wr_fire && w_strb_reg[1];
  assign wpal_idx = 3'((aw_addr_reg - ORS_ADDR_PAL) >> 2);

  // Address channel capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_reg    <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_got_reg    <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Data channel capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_reg    <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_reg    <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_got_reg    <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response, error for an unmapped address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ORS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_mapped(aw_addr_reg) ? ORS_RESP_OKAY : ORS_RESP_SLV;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Software-written registers
  // ---------------------------------------------------------------
  // Control bits of the status register and the configuration.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg  <= ORS_STAT_RST[7:2];
      cfg_reg  <= ORS_CFG_RST;
      mask_reg <= ORS_MASK_RST;
    end else begin
      if (lane0 && aw_addr_reg == ORS_ADDR_STAT) begin
        ctl_reg <= w_data_reg[7:2];
      end
      if (lane0 && aw_addr_reg == ORS_ADDR_CFG) begin
        cfg_reg[7:0] <= w_data_reg[7:0];
      end
      if (lane1 && aw_addr_reg == ORS_ADDR_CFG) begin
        cfg_reg[8] <= w_data_reg[8];
      end
      if (lane0 && aw_addr_reg == ORS_ADDR_MASK) begin
        mask_reg <= w_data_reg[1:0];
      end
    end
  end

  // Palette table, one entry per nonzero index.
  genvar gi;
  generate
    for (gi = 0; gi < ORS_NUM_PAL; gi++) begin : g_pal
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pal_reg[gi] <= ORS_PAL_RST;
        end else if (lane0 && addr_mapped(aw_addr_reg) && aw_addr_reg >= ORS_ADDR_PAL &&
                     wpal_idx == 3'(gi)) begin
          pal_reg[gi] <= w_data_reg[5:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Row timing: line counter advanced by hsync, cleared by vsync.
  // ---------------------------------------------------------------
  assign row_len = (cfg_reg[ORS_CF_DBL] ? ORS_LINES_DBL : ORS_LINES_NORM)
                 + {2'h0, cfg_reg[3:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_reg <= 6'h00;
      row_reg  <= 4'h0;
    end else if (v_lead) begin
      line_reg <= 6'h00;
      row_reg  <= 4'h0;
    end else if (h_lead) begin
      if (line_reg >= row_len - 6'h01) begin
        line_reg <= 6'h00;
        row_reg  <= row_reg + 4'h1;
      end else begin
        line_reg <= line_reg + 6'h01;
      end
    end
  end

  // Event pulses: the first hsync of a row and each vsync leading edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_start   <= 1'b0;
      field_start <= 1'b0;
    end else begin
      row_start   <= h_lead && !v_lead && line_reg == 6'h00;
      field_start <= v_lead;
    end
  end

  // ---------------------------------------------------------------
  // Event flags: a set in the same cycle as its clear wins.
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hflag_reg <= ORS_STAT_RST[ORS_ST_HFLAG];
      vflag_reg <= ORS_STAT_RST[ORS_ST_VFLAG];
    end else begin
      if (row_start) begin
        hflag_reg <= 1'b1;
      end else if (lane0 && aw_addr_reg == ORS_ADDR_STAT && w_data_reg[ORS_ST_HFLAG]) begin
        hflag_reg <= 1'b0;
      end
      if (field_start) begin
        vflag_reg <= 1'b1;
      end else if (lane0 && aw_addr_reg == ORS_ADDR_STAT && w_data_reg[ORS_ST_VFLAG]) begin
        vflag_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt service: first source is served, the other pends.
  // ---------------------------------------------------------------
  assign h_ok = hflag_reg && ctl_reg[ORS_ST_HEN] && mask_reg[ORS_ST_HFLAG];
  assign v_ok = vflag_reg && mask_reg[ORS_ST_VFLAG];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      srv_reg <= ORS_SRV_NONE;
    end else begin
      unique case (srv_reg)
        ORS_SRV_NONE: begin
          // Vertical wins when both arrive together.
          if (v_ok) begin
            srv_reg <= ORS_SRV_VERT;
          end else if (h_ok) begin
            srv_reg <= ORS_SRV_ROW;
          end
        end
        ORS_SRV_ROW: begin
          if (!h_ok) begin
            srv_reg <= ORS_SRV_NONE;
          end
        end
        ORS_SRV_VERT: begin
          if (!v_ok) begin
            srv_reg <= ORS_SRV_NONE;
          end
        end
        default: begin
          srv_reg <= ORS_SRV_NONE;
        end
      endcase
    end
  end

  // Level output while the served source stays set and enabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (srv_reg == ORS_SRV_ROW && h_ok) || (srv_reg == ORS_SRV_VERT && v_ok);
    end
  end

  // ---------------------------------------------------------------
  // Pixel colour: palette choice, then fringe.
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    logic [2:0] fg;
    logic [2:0] bg;
    fg = pix_row_fg;
    bg = pix_row_bg;
    if (!aresetn) begin
      pix_rgb       <= 3'h0;
      pix_rgb_valid <= 1'b0;
    end else begin
      pix_rgb_valid <= pix_valid;
      // Indexed colours only in palette mode with a nonzero index.
      if (ctl_reg[ORS_ST_PMODE] && pix_sel != 3'h0) begin
        fg = pal_reg[pix_sel - 3'h1][5:3];
        bg = pal_reg[pix_sel - 3'h1][2:0];
      end
      if (pix_edge && !pix_fore && cfg_reg[ORS_CF_FEN] && !cfg_reg[ORS_CF_PROG]) begin
        pix_rgb <= ctl_reg[ORS_ST_FSEL] ? ctl_reg[6:4] : bg;
      end else begin
        pix_rgb <= pix_fore ? fg : bg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign pal_idx = 3'((s_axi_araddr - ORS_ADDR_PAL) >> 2);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == ORS_ADDR_STAT) begin
      rd_word[7:0] = {ctl_reg, vflag_reg, hflag_reg};
    end else if (s_axi_araddr == ORS_ADDR_CFG) begin
      rd_word[8:0] = cfg_reg;
    end else if (s_axi_araddr == ORS_ADDR_MASK) begin
      rd_word[1:0] = mask_reg;
    end else if (s_axi_araddr == ORS_ADDR_LINE) begin
      rd_word[11:0] = {2'h0, row_reg, line_reg};
    end else if (addr_mapped(s_axi_araddr)) begin
      rd_word[5:0] = pal_reg[pal_idx];
    end
  end

  // One read at a time; address is refused while the answer stands.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ORS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= addr_mapped(s_axi_araddr) ? ORS_RESP_OKAY : ORS_RESP_SLV;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== tb/ors_sync_src.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Video front end model: free running lines, vsync on request.
// ---------------------------------------------------------------
module ors_sync_src #(
  parameter int LINE = 40,                       // Cycles in one scan line.
  parameter int HW   = 4,                        // Hsync pulse width in cycles.
  parameter int VLEN = 80                        // Vsync width, above 1.5 x (LINE + HW).
) (
  // Clock and reset.
  input  wire logic aclk,
  input  wire logic aresetn,
  // Request for one vsync pulse.
  input  wire logic field_go,
  // Sync pins, active high.
  output logic      hsync,
  output logic      vsync
);
  int   pos;                                     // Position within the line.
  int   vcnt;                                    // Cycles of vsync still to run.
  logic go_q;                                    // A vsync has been requested.

  // The line position wraps every LINE cycles.
  always_ff @(posedge aclk) begin
    if (!aresetn) pos <= 0;
    else pos <= (pos == LINE - 1) ? 0 : pos + 1;
  end

  // Hsync sits at the end of the line, so the first edge comes well after reset.
  assign hsync = aresetn && (pos >= LINE - HW);

  // Vsync starts mid-line, far from any hsync rising edge, and outlasts 1.5 lines.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vcnt <= 0;
      go_q <= 1'b0;
    end else begin
      if (field_go) go_q <= 1'b1;
      if (vcnt != 0) vcnt <= vcnt - 1;
      else if (go_q && pos == LINE / 2) begin
        vcnt <= VLEN;
        go_q <= 1'b0;
      end
    end
  end
  assign vsync = (vcnt != 0);
endmodule

// ==== tb/ors_top_asserts.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Port checker for ors_top: bus handshakes, pixel path and events.
// ---------------------------------------------------------------
module ors_top_asserts (
  // Clock and reset.
  input wire logic       aclk,
  input wire logic       aresetn,
  // Bus handshakes.
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Pixel path.
  input wire logic       pix_valid,
  input wire logic [2:0] pix_sel,
  input wire logic [2:0] pix_row_fg,
  input wire logic [2:0] pix_row_bg,
  input wire logic       pix_fore,
  input wire logic       pix_edge,
  input wire logic [2:0] pix_rgb,
  input wire logic       pix_rgb_valid,
  // Events.
  input wire logic       row_start,
  input wire logic       field_start
);
  logic [2:0] row_exp;                           // Row colour that a plain pixel must show.

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Row colour chosen by the previous request.
  always_ff @(posedge aclk) row_exp <= pix_fore ? pix_row_fg : pix_row_bg;

  wr_answer_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a:    assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("read answer late");
  b_hold_a:       assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid) else $error("bvalid dropped");
  r_hold_a:       assert property ((s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid) else $error("rvalid dropped");
  row_pulse_a:    assert property (row_start |=> !row_start) else $error("row pulse too long");
  field_pulse_a:  assert property (field_start |=> !field_start) else $error("field pulse too long");
  events_apart_a: assert property (!(row_start && field_start)) else $error("row and field together");
  pix_valid_a:    assert property (pix_valid |=> pix_rgb_valid) else $error("pixel valid missing");
  pix_row_a:      assert property ((pix_valid && pix_sel == 3'h0 && !pix_edge) |=> pix_rgb == row_exp)
    else $error("row colour wrong");
endmodule

bind ors_top ors_top_asserts chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pix_valid(pix_valid), .pix_sel(pix_sel),
  .pix_row_fg(pix_row_fg), .pix_row_bg(pix_row_bg), .pix_fore(pix_fore), .pix_edge(pix_edge),
  .pix_rgb(pix_rgb), .pix_rgb_valid(pix_rgb_valid), .row_start(row_start), .field_start(field_start));

// ==== tb/osd_row_sync_interrupts_test.sv ====
`timescale 1ns/1ps
module osd_row_sync_interrupts_test;
  import ors_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        aclk = 1'b0, aresetn = 1'b0, field_go = 1'b0, hsync, vsync, hs_q, irq;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, row_start, field_start;
  logic        pix_valid = 1'b0, pix_fore = 1'b0, pix_edge = 1'b0, pix_rgb_valid;
  logic [2:0]  pix_sel = 3'h0, pix_rgb;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_data;
  logic [1:0]  bresp, rresp, wr_resp, rd_resp;
  int          fail_count = 0, checks_done = 0, hs_cnt = 0, cycles = 0;

  ors_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hsync(hsync), .vsync(vsync),
    .pix_valid(pix_valid), .pix_sel(pix_sel), .pix_row_fg(3'h1), .pix_row_bg(3'h3), .pix_fore(pix_fore),
    .pix_edge(pix_edge), .pix_rgb(pix_rgb), .pix_rgb_valid(pix_rgb_valid), .row_start(row_start),
    .field_start(field_start), .irq(irq));
  ors_sync_src src_u (.aclk(aclk), .aresetn(aresetn), .field_go(field_go), .hsync(hsync), .vsync(vsync));

  always #12.5 aclk = ~aclk;

  // Counts hsync rising edges and cuts a hang short.
  always @(posedge aclk) begin
    hs_q <= hsync;
    if (hsync && !hs_q) hs_cnt <= hs_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      give_verdict();
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write with address and data offered together; each drops once taken.
  task wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, wd;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1; ad = 0; wd = 0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready && !ad) begin ad = 1; awvalid <= 1'b0; end
      if (wready && !wd) begin wd = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_data = rdata; rd_resp = rresp; rready <= 1'b0;
  endtask

  task wait_row;
    do @(posedge aclk); while (row_start !== 1'b1);
  endtask

  task test_reset;
    rd(ORS_ADDR_STAT); chk("status", 32'h0, rd_data);
    rd(ORS_ADDR_CFG); chk("cfg", 32'h0, rd_data);
    rd(8'h40); chk("unmapped rresp", 32'h2, rd_resp);
    wr(8'h40, 32'hff); chk("unmapped bresp", 32'h2, wr_resp);
    wr(ORS_ADDR_MASK, 32'h3); rd(ORS_ADDR_MASK); chk("mask", 32'h3, rd_data);
    $display("test_reset done");
  endtask

  // Counts hsyncs between two row events once the new length has settled.
  task test_rowlen(input logic [31:0] cfg, input int exp);
    int h0;
    wr(ORS_ADDR_CFG, cfg); wait_row; wait_row;
    h0 = hs_cnt; wait_row;
    chk("row lines", exp, hs_cnt - h0);
    $display("test_rowlen done");
  endtask

  // Vertical event is served, the row event pends behind it, then the enable gates it.
  task test_field;
    wr(ORS_ADDR_STAT, 32'h07);
    @(posedge aclk) field_go <= 1'b1;
    @(posedge aclk) field_go <= 1'b0;
    do @(posedge aclk); while (field_start !== 1'b1);
    repeat (5) @(posedge aclk);
    chk("irq field", 1, irq);
    wait_row; repeat (8) @(posedge aclk);
    rd(ORS_ADDR_STAT); chk("both flags", 32'h07, rd_data);
    rd(ORS_ADDR_LINE); chk("line pos", 32'h1, rd_data);
    wr(ORS_ADDR_STAT, 32'h06); repeat (6) @(posedge aclk);
    chk("irq pended", 1, irq);
    rd(ORS_ADDR_STAT); chk("vflag clear", 32'h05, rd_data);
    wr(ORS_ADDR_STAT, 32'h01); repeat (4) @(posedge aclk);
    chk("irq clear", 0, irq);
    wait_row; repeat (8) @(posedge aclk);
    chk("irq row off", 0, irq);
    rd(ORS_ADDR_STAT); chk("hflag", 32'h01, rd_data);
    $display("test_field done");
  endtask

  task px(input logic [2:0] s, input logic f, input logic e, input logic [2:0] exp);
    @(posedge aclk);
    pix_sel <= s; pix_fore <= f; pix_edge <= e; pix_valid <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    chk("pix_rgb", {29'h0, exp}, {29'h0, pix_rgb});
  endtask

  // Palette 1 holds foreground 5 and background 2; row colours are 1 and 3.
  task test_pixel;
    wr(ORS_ADDR_PAL, 32'h2a); wr(ORS_ADDR_CFG, 32'h40); wr(ORS_ADDR_STAT, 32'he8);
    px(3'h1, 1'b1, 1'b0, 3'h5);
    px(3'h0, 1'b1, 1'b0, 3'h1);
    px(3'h0, 1'b0, 1'b1, 3'h6);
    wr(ORS_ADDR_STAT, 32'h68); px(3'h1, 1'b0, 1'b1, 3'h2);
    wr(ORS_ADDR_STAT, 32'he0); px(3'h1, 1'b1, 1'b0, 3'h1);
    wr(ORS_ADDR_CFG, 32'h60); px(3'h0, 1'b0, 1'b1, 3'h3);
    $display("test_pixel done");
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset;
    test_rowlen(32'h00, 18);
    test_rowlen(32'h10, 36);
    test_rowlen(32'h0f, 33);
    test_rowlen(32'h13, 39);
    test_field;
    test_pixel;
    give_verdict();
  end
endmodule
